// ===== src/tsi_dev.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// (RQ1) Master originates transfers and makes the clock.
// (RQ2) Clock is input only; data open-drain.
// (RQ3) Idle bus: both lines released high.
// (RQ4) Data falling while clock high starts.
// (RQ5) Data rising while clock high stops.
// (RQ6) One bit per clock, stable while high.
// (RQ7) Ninth clock carries receiver's low acknowledge.
// (RQ8) Device acks writes; master acks reads.
// (RQ9) First byte: address then direction bit.
// (RQ10) Watch for start plus own address.
// (RQ11) Address is 0x4A or 0x4B per variant.
// (RQ12) Start, address, pointer, data bytes, stop.
// (RQ13) First written byte sets register pointer.
// (RQ14) Stop after pointer byte: keep pointer only.
// (RQ15) First data byte goes to pointed register.
// (RQ16) Later data bytes go to following registers.
// (RQ17) Serial rates up to 400 kbit/s.
// (RQ18) Interrupt pin active low, open drain.
// (RQ19) Interrupt on any electrode status change.
// (RQ20) Read: pointer write, repeated start, bytes out.
// (RQ21) Pointer wraps from 0x44 to 0x00.
// (RQ22) Pin starts as interrupt, released.
// (RQ23) Foreign address: release data, wait start.
// ---------------------------------------------------------------------
// Touch sensor two-wire slave
// ---------------------------------------------------------------------
module tsi_dev #(
  parameter bit VARIANT_B = 1'b0
) (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Two-wire link
  tsi_bus_if.dev bus,
  // Register write side
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // Register read side
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Electrode status and pin function
  input wire logic [2:0] touch_status,
  input wire logic pin_mode_wr,
  input wire logic pin_mode_elec,
  output logic third_pin_is_irq
);

  typedef enum {
    D_IDLE,
    D_ADDR,
    D_AACK,
    D_CMD,
    D_CACK,
    D_WDAT,
    D_WACK,
    D_RDAT,
    D_RACK,
    D_SKIP
  } tsi_dst_t;

  localparam logic [6:0] OWN_ADDR =
    VARIANT_B ? tsi_pkg::ADDR_VAR_B : tsi_pkg::ADDR_VAR_A; // RQ11

  // -------------------------------------------------------------------
  // Line sampling
  // -------------------------------------------------------------------
  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Two flops per line; a third keeps the last settled level for edges.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end
    else
    begin
      scl_s1 <= bus.scl; // RQ2
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // Edges and bus conditions; at 50 MHz a 400 kbit/s bit is 125 cycles.
  assign scl_rise = scl_s2 & ~scl_s3; // RQ17
  assign scl_fall = ~scl_s2 & scl_s3;
  assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2; // RQ4
  assign bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2; // RQ5

  // -------------------------------------------------------------------
  // Transfer engine
  // -------------------------------------------------------------------
  tsi_dst_t st_r;
  tsi_dst_t st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] ptr_inc;
  logic low_r;
  logic low_nxt;
  logic rw_r;
  logic rw_nxt;
  logic nack_r;
  logic nack_nxt;
  logic wr_stb_nxt;
  logic [7:0] wr_addr_nxt;
  logic [7:0] wr_data_nxt;
  logic load_rd;
  logic rd_clr;

  // Next pointer wraps after the highest register.
  assign ptr_inc = (ptr_r == tsi_pkg::PTR_LAST) ? tsi_pkg::PTR_WRAP :
    ptr_r + 8'h01; // RQ21

  // Data only changes on a falling clock, so it is stable while high.
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    low_nxt = low_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    wr_stb_nxt = 1'b0;
    wr_addr_nxt = wr_addr;
    wr_data_nxt = wr_data;
    load_rd = 1'b0;
    if (bus_stop)
    begin
      st_nxt = D_IDLE; // RQ5
      low_nxt = 1'b0; // RQ14
    end
    else if (bus_start)
    begin
      st_nxt = D_ADDR; // RQ10
      cnt_nxt = 4'h0;
      low_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        D_ADDR, D_CMD, D_WDAT:
        begin
          if (scl_rise)
          begin
            sh_nxt = {sh_r[6:0], sda_s2}; // RQ6
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == tsi_pkg::BYTE_BITS)
          begin
            cnt_nxt = 4'h0;
            low_nxt = 1'b1; // RQ7 RQ8
            if (st_r == D_ADDR)
            begin
              rw_nxt = sh_r[0]; // RQ9
              if (sh_r[7:1] == OWN_ADDR)
                st_nxt = D_AACK; // RQ10
              else
              begin
                st_nxt = D_SKIP; // RQ23
                low_nxt = 1'b0;
              end
            end
            else if (st_r == D_CMD)
            begin
              ptr_nxt = sh_r; // RQ13
              st_nxt = D_CACK;
            end
            else
            begin
              wr_stb_nxt = 1'b1; // RQ15
              wr_addr_nxt = ptr_r;
              wr_data_nxt = sh_r;
              st_nxt = D_WACK;
            end
          end
        end
        D_AACK, D_CACK, D_WACK:
        begin
          if (scl_fall)
          begin
            low_nxt = 1'b0;
            if (st_r == D_WACK)
              ptr_nxt = ptr_inc; // RQ16
            if (st_r == D_AACK && rw_r)
              load_rd = 1'b1; // RQ20
            else if (st_r == D_AACK)
              st_nxt = D_CMD;
            else
              st_nxt = D_WDAT;
          end
        end
        D_RDAT:
        begin
          if (scl_rise)
            cnt_nxt = cnt_r + 4'h1;
          else if (scl_fall && cnt_r == tsi_pkg::BYTE_BITS)
          begin
            low_nxt = 1'b0; // RQ8
            cnt_nxt = 4'h0;
            st_nxt = D_RACK;
          end
          else if (scl_fall)
          begin
            sh_nxt = {sh_r[6:0], 1'b0};
            low_nxt = ~sh_r[6]; // RQ6
          end
        end
        D_RACK:
        begin
          if (scl_rise)
            nack_nxt = sda_s2; // RQ8
          else if (scl_fall && !nack_r)
            load_rd = 1'b1; // RQ20
          else if (scl_fall)
            st_nxt = D_SKIP;
        end
        default:
        begin
          low_nxt = 1'b0; // RQ3
        end
      endcase
    end
    // Start a read byte: first bit goes out on this falling edge.
    if (load_rd)
    begin
      sh_nxt = rd_data;
      low_nxt = ~rd_data[7];
      ptr_nxt = ptr_inc; // RQ21
      cnt_nxt = 4'h0;
      st_nxt = D_RDAT;
    end
  end

  // A read of the status register acknowledges the interrupt.
  assign rd_clr = load_rd && (ptr_r == tsi_pkg::PTR_STATUS);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= D_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      low_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b1;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      low_r <= low_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      wr_stb <= wr_stb_nxt;
      wr_addr <= wr_addr_nxt;
      wr_data <= wr_data_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Interrupt and shared pin
  // -------------------------------------------------------------------
  logic [2:0] prev_r;
  logic pend_r;
  logic pend_nxt;
  logic mode_r;
  logic mode_nxt;
  logic irq_low_r;
  logic irq_low_nxt;

  // A change beats a clear in the same cycle so no event is lost.
  always_comb
  begin
    pend_nxt = (touch_status != prev_r) | (pend_r & ~rd_clr); // RQ19
    mode_nxt = pin_mode_wr ? ~pin_mode_elec : mode_r;
    irq_low_nxt = pend_nxt & mode_nxt; // RQ18
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r <= 3'h0;
      pend_r <= 1'b0;
      mode_r <= 1'b1; // RQ22
      irq_low_r <= 1'b0;
    end
    else
    begin
      prev_r <= touch_status;
      pend_r <= pend_nxt;
      mode_r <= mode_nxt;
      irq_low_r <= irq_low_nxt;
    end
  end

  // Open-drain drivers: only ever pull low.
  assign bus.sda_d_o = 1'b0; // RQ2
  assign bus.sda_d_oe = low_r;
  assign bus.irq_o = 1'b0; // RQ18
  assign bus.irq_oe = irq_low_r;
  assign rd_addr = ptr_r;
  assign third_pin_is_irq = mode_r;

endmodule
`default_nettype wire

// ===== src/tsi_pkg.sv
// ---------------------------------------------------------------------
// Shared constants of the touch sensor two-wire link
// ---------------------------------------------------------------------
package tsi_pkg;

  // Bus addresses of the two variants.
  localparam logic [6:0] ADDR_VAR_A = 7'h4A;
  localparam logic [6:0] ADDR_VAR_B = 7'h4B;

  // Register pointer: highest register and where it wraps to.
  localparam logic [7:0] PTR_LAST = 8'h44;
  localparam logic [7:0] PTR_WRAP = 8'h00;
  localparam logic [7:0] PTR_STATUS = 8'h00;

  // Bits clocked per byte before the acknowledge bit.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Timing: system clock and the serial clock made by the master.
  localparam int CLK_NS = 20;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_NS = SCL_PERIOD_NS / 4;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

  // Master command set.
  typedef enum logic [1:0] {
    OP_START,
    OP_STOP,
    OP_WRITE,
    OP_READ
  } tsi_op_t;

endpackage

// ===== src/tsi_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Open-drain two-wire link between master and touch sensor
// ---------------------------------------------------------------------
interface tsi_bus_if;
  // Drivers of each party; an enable pulls the line low.
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic irq_o;
  logic irq_oe;
  // Wired levels with the pull-ups folded in.
  logic scl;
  logic sda;
  logic irq;

  // A line is low when any enabled driver puts a low on it.
  assign scl = ~(scl_h_oe & ~scl_h_o);
  assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);
  assign irq = ~(irq_oe & ~irq_o);

  modport dev (
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe,
    output irq_o,
    output irq_oe
  );

  modport host (
    input scl,
    input sda,
    input irq,
    output scl_h_o,
    output scl_h_oe,
    output sda_h_o,
    output sda_h_oe
  );
endinterface
`default_nettype wire

// ===== src/tsi_host.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Two-wire master driving the touch sensor
// ---------------------------------------------------------------------
module tsi_host (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Two-wire link
  tsi_bus_if.host bus,
  // Command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tsi_pkg::tsi_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  // Answer side
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic irq_seen
);

  typedef enum {
    H_IDLE,
    H_RUN
  } tsi_hst_t;

  // -------------------------------------------------------------------
  // Line sampling
  // -------------------------------------------------------------------
  logic sda_s1;
  logic sda_s2;
  logic irq_s1;
  logic irq_s2;

  // Link lines come from outside and pass two flops first.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      irq_s1 <= bus.irq;
      irq_s2 <= irq_s1;
    end
  end

  // -------------------------------------------------------------------
  // Bit engine: four quarters per clock period
  // -------------------------------------------------------------------
  tsi_hst_t st_r;
  tsi_hst_t st_nxt;
  tsi_pkg::tsi_op_t op_r;
  tsi_pkg::tsi_op_t op_nxt;
  logic [5:0] div_r;
  logic [5:0] div_nxt;
  logic [1:0] q_r;
  logic [1:0] q_nxt;
  logic [3:0] b_r;
  logic [3:0] b_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic ack_r;
  logic ack_nxt;
  logic scl_low_r;
  logic scl_low_nxt;
  logic sda_low_r;
  logic sda_low_nxt;
  logic nack_nxt;
  logic rsp_nxt;
  logic last_bit;
  logic is_byte;
  logic tick;

  assign is_byte = (op_r == tsi_pkg::OP_WRITE) || (op_r == tsi_pkg::OP_READ);
  assign last_bit = is_byte ? (b_r == tsi_pkg::BYTE_BITS) : 1'b1;
  assign tick = (st_r == H_RUN) && (div_r == tsi_pkg::QTR_LAST);
  assign cmd_ready = (st_r == H_IDLE);

  // Data moves a quarter after the clock falls, never with it, so the
  // slave cannot mistake a change for a start or stop.
  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    div_nxt = div_r;
    q_nxt = q_r;
    b_nxt = b_r;
    sh_nxt = sh_r;
    ack_nxt = ack_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    nack_nxt = rsp_nack;
    rsp_nxt = 1'b0;
    case (st_r)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          op_nxt = cmd_op;
          sh_nxt = cmd_data;
          ack_nxt = cmd_ack;
          div_nxt = 6'h00;
          q_nxt = 2'h0;
          b_nxt = 4'h0;
          scl_low_nxt = 1'b1; // RQ1
          st_nxt = H_RUN;
        end
      end
      H_RUN:
      begin
        div_nxt = tick ? 6'h00 : div_r + 6'h01;
        if (tick && q_r == 2'h3)
        begin
          if (last_bit)
          begin
            rsp_nxt = 1'b1;
            st_nxt = H_IDLE;
          end
          else
          begin
            b_nxt = b_r + 4'h1;
            q_nxt = 2'h0;
            scl_low_nxt = 1'b1; // RQ6
          end
        end
        else if (tick)
        begin
          q_nxt = q_r + 2'h1;
          if (q_r == 2'h0)
          begin
            case (op_r)
              tsi_pkg::OP_START: sda_low_nxt = 1'b0;
              tsi_pkg::OP_STOP: sda_low_nxt = 1'b1;
              tsi_pkg::OP_WRITE:
                sda_low_nxt = last_bit ? 1'b0 : ~sh_r[7]; // RQ8
              default:
                sda_low_nxt = last_bit ? ack_r : 1'b0; // RQ7
            endcase
          end
          else if (q_r == 2'h1)
            scl_low_nxt = 1'b0;
          else
          begin
            if (op_r == tsi_pkg::OP_START)
              sda_low_nxt = 1'b1; // RQ4
            else if (op_r == tsi_pkg::OP_STOP)
              sda_low_nxt = 1'b0; // RQ5
            else if (last_bit)
              nack_nxt = sda_s2; // RQ7
            else
              sh_nxt = {sh_r[6:0], sda_s2}; // RQ6
          end
        end
      end
      default:
      begin
        st_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= H_IDLE;
      op_r <= tsi_pkg::OP_STOP;
      div_r <= 6'h00;
      q_r <= 2'h0;
      b_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      scl_low_r <= 1'b0; // RQ3
      sda_low_r <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_valid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      div_r <= div_nxt;
      q_r <= q_nxt;
      b_r <= b_nxt;
      sh_r <= sh_nxt;
      ack_r <= ack_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
      rsp_nack <= nack_nxt;
      rsp_valid <= rsp_nxt;
    end
  end

  // Open-drain drivers; the answer byte is the shift register.
  assign bus.scl_h_o = 1'b0; // RQ1
  assign bus.scl_h_oe = scl_low_r;
  assign bus.sda_h_o = 1'b0;
  assign bus.sda_h_oe = sda_low_r;
  assign rsp_data = sh_r;
  assign irq_seen = ~irq_s2;

endmodule
`default_nettype wire

// ===== test/tsi_link_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// Link checker
// ----------
module tsi_link_checker #(
  parameter logic [6:0] DEV_ADDR = 7'h4A
) (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wired levels
  input wire logic scl,
  input wire logic sda,
  // Device drivers
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic irq_o,
  input wire logic irq_oe
);
  logic scl_r, sda_r, first_r, first_nxt, quiet_r, quiet_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt, low_r, low_nxt;

  // Bit tracker; edges come from registered copies of the lines.
  always_comb
  begin
    bit_nxt = bit_r;
    first_nxt = first_r;
    shift_nxt = shift_r;
    quiet_nxt = quiet_r;
    low_nxt = scl ? 8'h00 : low_r + 8'h01;
    if (scl && scl_r && sda_r && !sda)
    begin
      bit_nxt = 4'h0;
      first_nxt = 1'b1;
      quiet_nxt = 1'b0;
    end
    else if (scl && !scl_r)
    begin
      shift_nxt = {shift_r[6:0], sda};
      bit_nxt = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      first_nxt = first_r && (bit_r != 4'h8);
      quiet_nxt = quiet_r | (first_r && bit_r == 4'h7
        && shift_nxt[7:1] != DEV_ADDR);
    end
  end

  // Reset makes the bus look idle, so no edge is seen at release.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      bit_r <= 4'h0;
      first_r <= 1'b0;
      shift_r <= 8'h00;
      quiet_r <= 1'b0;
      low_r <= 8'h00;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      bit_r <= bit_nxt;
      first_r <= first_nxt;
      shift_r <= shift_nxt;
      quiet_r <= quiet_nxt;
      low_r <= low_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Framing and the acknowledge slot of an address naming this device.
  sequence seq_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence seq_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence seq_addr_ack;
    $rose(scl) && bit_r == 4'h8 && first_r && shift_r[7:1] == DEV_ADDR;
  endsequence

  chk_sda_drain: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drives the data line high");
  chk_irq_drain: assert property (irq_oe |-> !irq_o)
    else $error("interrupt pin driven high");
  chk_data_hold: assert property
    (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("device data moved while clock high");
  chk_start_quiet: assert property (seq_start |-> (!sda_d_oe) [*8])
    else $error("device drives data right after a start");
  chk_stop_idle: assert property (seq_stop |-> (scl && sda) [*8])
    else $error("bus not left idle after a stop");
  chk_addr_ack: assert property
    (seq_addr_ack |-> (!sda && sda_d_oe) [*8])
    else $error("own address not acknowledged");
  chk_foreign_quiet: assert property (quiet_r |-> !sda_d_oe)
    else $error("device drives data after a foreign address");
  chk_scl_low: assert property ($rose(scl) |-> low_r >= 8'h3C)
    else $error("clock low phase too short");
endmodule
`default_nettype wire

// ===== test/test_touch_sensor_i2c_slave.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// Bench: host end talks to device end
// ----------
module test_touch_sensor_i2c_slave;
  localparam logic [6:0] DEV_ADDR = tsi_pkg::ADDR_VAR_B;
  localparam int MAX_CYC = 90000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ack = 1'b0;
  logic pin_mode_wr = 1'b0;
  logic pin_mode_elec = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic [2:0] touch_status = 3'h0;
  tsi_pkg::tsi_op_t cmd_op = tsi_pkg::OP_STOP;
  logic cmd_ready, rsp_valid, rsp_nack, irq_seen, wr_stb, third_pin_is_irq;
  logic [7:0] rsp_data, wr_addr, wr_data, rd_addr, rd_data;
  logic [6:0] fa;
  logic [4:0] pins;
  logic [10:0] rsp_q[$];
  logic [15:0] wr_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 99575;
  int cyc = 0;
  int i;

  tsi_bus_if tsi_bus_if_inst ();

  // Register stand-in reads back its address mixed; pins are watched as
  // {irq seen, irq wire, pin is irq, clock wire, data wire}.
  assign rd_data = rd_addr ^ 8'h5A;
  assign pins = {irq_seen, tsi_bus_if_inst.irq, third_pin_is_irq,
    tsi_bus_if_inst.scl, tsi_bus_if_inst.sda};

  // System clock.
  always #10 clk_sys = ~clk_sys;

  // Device end at the second variant's address.
  tsi_dev #(.VARIANT_B(1'b1)) tsi_dev_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(tsi_bus_if_inst),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .touch_status(touch_status),
    .pin_mode_wr(pin_mode_wr), .pin_mode_elec(pin_mode_elec),
    .third_pin_is_irq(third_pin_is_irq));
  tsi_host tsi_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(tsi_bus_if_inst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .irq_seen(irq_seen));
  tsi_link_checker #(.DEV_ADDR(DEV_ADDR)) tsi_link_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(tsi_bus_if_inst.scl),
    .sda(tsi_bus_if_inst.sda), .sda_d_o(tsi_bus_if_inst.sda_d_o),
    .sda_d_oe(tsi_bus_if_inst.sda_d_oe), .irq_o(tsi_bus_if_inst.irq_o),
    .irq_oe(tsi_bus_if_inst.irq_oe));

  // Shared comparison and report.
  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Host answer: a write gives the ack, a read the byte and master ack.
  task automatic check_rsp(input logic [10:0] note);
    if (note[10:9] == 2'(tsi_pkg::OP_WRITE))
      report({15'h0000, rsp_nack}, {15'h0000, note[8]});
    else if (note[10:9] == 2'(tsi_pkg::OP_READ))
      report({7'h00, rsp_nack, rsp_data}, {7'h00, note[8:0]});
  endtask

  // Device register write as address and data.
  task automatic check_wr(input logic [15:0] exp);
    report({wr_addr, wr_data}, exp);
  endtask

  // Level outputs and wire levels.
  task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
    report({8'h00, got}, {8'h00, exp});
  endtask

  // Pointer step with the wrap after the last register.
  function automatic logic [7:0] nxt_ptr(input logic [7:0] p);
    return (p == tsi_pkg::PTR_LAST) ? tsi_pkg::PTR_WRAP : p + 8'h01;
  endfunction

  // Counts and verdict; the only way the run ends.
  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One master command: note its answer, hold it until taken, then wait
  // for the answer so the next command never overlaps.
  task automatic hcmd(input tsi_pkg::tsi_op_t op, input logic [7:0] d,
    input logic a, input logic [8:0] exp);
    int n;
    rsp_q.push_back({2'(op), exp});
    @(posedge clk_sys);
    #1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    for (n = 0; n < 1300 && rsp_valid !== 1'b1; n++) @(posedge clk_sys);
    // A command that never answers would otherwise slip by unnoticed.
    if (rsp_valid !== 1'b1)
      report(16'h0000, 16'h0001);
  endtask

  // Pointer write, nw random data bytes, then nr bytes read back after a
  // repeated start; the last read byte is refused by the master.
  task automatic xfer(input logic [7:0] ptr, input int nw, input int nr);
    logic [7:0] p;
    logic [7:0] d;
    int k;
    p = ptr;
    hcmd(tsi_pkg::OP_START, 8'h00, 1'b0, 9'h000);
    hcmd(tsi_pkg::OP_WRITE, {DEV_ADDR, 1'b0}, 1'b0, 9'h000);
    hcmd(tsi_pkg::OP_WRITE, ptr, 1'b0, 9'h000);
    for (k = 0; k < nw; k++)
    begin
      d = 8'($random(seed));
      wr_q.push_back({p, d});
      hcmd(tsi_pkg::OP_WRITE, d, 1'b0, 9'h000);
      p = nxt_ptr(p);
    end
    if (nr > 0)
      hcmd(tsi_pkg::OP_START, 8'h00, 1'b0, 9'h000);
    if (nr > 0)
      hcmd(tsi_pkg::OP_WRITE, {DEV_ADDR, 1'b1}, 1'b0, 9'h000);
    for (k = 0; k < nr; k++)
    begin
      hcmd(tsi_pkg::OP_READ, 8'h00, k < nr - 1,
        {k == nr - 1, p ^ 8'h5A});
      p = nxt_ptr(p);
    end
    hcmd(tsi_pkg::OP_STOP, 8'h00, 1'b0, 9'h000);
  endtask

  // Result watcher and cycle limit.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (rsp_valid === 1'b1 && rsp_q.size() == 0)
      report(16'h0000, 16'h0001);
    else if (rsp_valid === 1'b1)
      check_rsp(rsp_q.pop_front());
    if (wr_stb === 1'b1)
      check_wr(wr_q.size() > 0 ? wr_q.pop_front() : 16'hXXXX);
    if (cyc == MAX_CYC)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check_pin({3'h0, pins}, 8'h0F);
    xfer(8'h42, 4, 0);
    xfer(8'h10, 0, 0);
    check_pin(rd_addr, 8'h10);
    xfer(8'h43, 1, 3);
    for (i = 0; i < 2; i++)
    begin
      fa = (i == 0) ? tsi_pkg::ADDR_VAR_A : 7'($random(seed));
      if (fa == DEV_ADDR)
        fa = fa ^ 7'h01;
      hcmd(tsi_pkg::OP_START, 8'h00, 1'b0, 9'h000);
      hcmd(tsi_pkg::OP_WRITE, {fa, i[0]}, 1'b0, 9'h100);
      hcmd(tsi_pkg::OP_WRITE, 8'($random(seed)), 1'b0, 9'h100);
      hcmd(tsi_pkg::OP_STOP, 8'h00, 1'b0, 9'h000);
    end
    xfer(8'h05, 0, 1);
    #1 touch_status = 3'($random(seed)) | 3'h1;
    for (i = 0; i < 200 && irq_seen !== 1'b1; i++) @(posedge clk_sys);
    #1 check_pin({3'h0, pins}, 8'h17);
    xfer(tsi_pkg::PTR_STATUS, 0, 1);
    check_pin({3'h0, pins}, 8'h0F);
    #1 pin_mode_elec = 1'b1;
    pin_mode_wr = 1'b1;
    @(posedge clk_sys);
    #1 pin_mode_wr = 1'b0;
    touch_status = touch_status ^ 3'h2;
    repeat (40) @(posedge clk_sys);
    #1 check_pin({3'h0, pins}, 8'h0B);
    // Back to interrupt duty: the change seen meanwhile is still pending.
    #1 pin_mode_elec = 1'b0;
    pin_mode_wr = 1'b1;
    @(posedge clk_sys);
    #1 pin_mode_wr = 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 check_pin({3'h0, pins}, 8'h17);
    report(16'(rsp_q.size() + wr_q.size()), 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
